// *** rtl/interrupt_controller_unit_prio_pick.sv ***
// Level and priority constants, plus the winning-source picker
package interrupt_controller_unit_lp_pkg;
  localparam int          NUM_SRC        = 63;
  localparam int          FIRST_WRITABLE = 8;
  localparam logic [7:0]  ADDR_RECORD    = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_LO   = 8'h01;
  localparam logic [7:0]  ADDR_CTRL_HI   = 8'h3F;
  localparam logic [7:0]  ADDR_WR_LO     = 8'h08;
  localparam logic [7:0]  ADDR_SW_ACK    = 8'h40;
  localparam logic [7:0]  ADDR_LVL_ACK_LO = 8'h41;
  localparam logic [7:0]  ADDR_LVL_ACK_HI = 8'h47;
  localparam logic [5:0]  CTRL_RESET     = 6'h00;
  localparam logic [2:0]  LVL_DISABLED   = 3'h0;
  localparam logic [2:0]  PRI_FIXED_READ = 3'h0;
  localparam logic [2:0]  PRI_SPLIT      = 3'h4;
  localparam logic [3:0]  RANK_MID       = 4'h4;
  localparam logic [3:0]  PRI_MID        = 4'h8;
  localparam logic [3:0]  RANK_ONE       = 4'h1;
  // Source map; flags clear inside their own peripherals
  localparam int SRC_WATCHDOG       = 8;
  localparam int SRC_DMA_FIRST      = 9;
  localparam int SRC_SERIAL_FIRST   = 13;
  localparam int SRC_UNUSED         = 16;
  localparam int SRC_QUEUED_SERIAL  = 18;
  localparam int SRC_TIMER_FIRST    = 19;
  localparam int SRC_PERIODIC_FIRST = 36;
  // Bit per source that is wired; 0, 16 and 43-63 never win
  localparam logic [63:0] USED_MASK = 64'h0000_07FF_FFFE_FFFE;

  // Fixed slots rank at the gap between priority 3 and 4
  function automatic logic [3:0] rank_of(input logic fixed,
                                         input logic [2:0] acked_priority_field);
    if (fixed)
      return RANK_MID;
    else if (acked_priority_field < PRI_SPLIT)
      return {1'b0, acked_priority_field};
    else
      return 4'({1'b0, acked_priority_field} + RANK_ONE);
  endfunction

  function automatic logic [3:0] record_pri(input logic [3:0] rank);
    if (rank == RANK_MID)
      return PRI_MID;
    else if (rank < RANK_MID)
      return rank;
    else
      return 4'(rank - RANK_ONE);
  endfunction
endpackage

`timescale 1ns/1ns
`default_nettype none

module interrupt_controller_unit_prio_pick (
  input  wire logic [63:1]      i_req,
  input  wire logic [63:1][5:0] i_ctrl,
  input  wire logic [2:0]       i_level_filter,
  output logic                  o_found,
  output logic [5:0]            o_src,
  output logic [2:0]            o_level,
  output logic [3:0]            o_rank
);
  import interrupt_controller_unit_lp_pkg::*;

  logic [2:0] lvl;
  logic [3:0] rnk;

  // Strict compare: ties keep the lower source, though ties are illegal
  always_comb begin
    lvl     = LVL_DISABLED;
    rnk     = 4'h0;
    o_found = 1'b0;
    o_src   = 6'h00;
    o_level = LVL_DISABLED;
    o_rank  = 4'h0;
    for (int i = 1; i <= NUM_SRC; i++) begin
      lvl = i_ctrl[i][5:3];
      rnk = rank_of(i < FIRST_WRITABLE, i_ctrl[i][2:0]);
      if (i_req[i] && USED_MASK[i] && lvl != LVL_DISABLED &&
          (i_level_filter == LVL_DISABLED || lvl == i_level_filter) &&
          (!o_found || {lvl, rnk} > {o_level, o_rank})) begin
        o_found = 1'b1;
        o_src   = 6'(i);
        o_level = lvl;
        o_rank  = rnk;
      end
    end
  end
endmodule // interrupt_controller_unit_prio_pick

`default_nettype wire

// *** rtl/interrupt_controller_unit_level_priority_ack.sv ***
// Level and priority assignment with acknowledge record
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module interrupt_controller_unit_level_priority_ack #(
  parameter logic [7:0] VECTOR_BASE = 8'h40
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  input  wire logic [63:1] I_REQ,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic [7:0]      O_RDATA,
  output logic [2:0]      O_IRQ_LEVEL,
  output logic [5:0]      O_ACK_SOURCE
);
  import interrupt_controller_unit_lp_pkg::*;

  typedef struct packed {
    logic [63:1][5:0] ctrl;
    logic [7:0]       record;
    logic [7:0]       rdata;
    logic [2:0]       irq_level;
    logic [5:0]       ack_src;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic       is_ctrl;
  logic       is_writable;
  logic       is_ack;
  logic [2:0] ack_filter;
  logic       ack_found;
  logic [5:0] ack_src;
  logic [2:0] ack_level;
  logic [3:0] ack_rank;
  logic       top_found;
  logic [2:0] top_level;

  // Fixed sources carry their own index as level, priority field zero
  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int i = 1; i < FIRST_WRITABLE; i++) begin
      s.ctrl[i] = {3'(i), PRI_FIXED_READ};
    end
    for (int i = FIRST_WRITABLE; i <= NUM_SRC; i++) begin
      s.ctrl[i] = CTRL_RESET;
    end
    return s;
  endfunction

  assign is_ctrl     = I_ADDR >= ADDR_CTRL_LO && I_ADDR <= ADDR_CTRL_HI;
  assign is_writable = I_ADDR >= ADDR_WR_LO && I_ADDR <= ADDR_CTRL_HI;
  assign is_ack      = I_ADDR >= ADDR_SW_ACK && I_ADDR <= ADDR_LVL_ACK_HI;
  // Software ack looks at all levels, level-n ack at one
  assign ack_filter  = (I_ADDR == ADDR_SW_ACK) ? LVL_DISABLED : I_ADDR[2:0];

  interrupt_controller_unit_prio_pick u_ack_pick (
    .i_req          (I_REQ),
    .i_ctrl         (state_reg.ctrl),
    .i_level_filter (ack_filter),
    .o_found        (ack_found),
    .o_src          (ack_src),
    .o_level        (ack_level),
    .o_rank         (ack_rank)
  );

  interrupt_controller_unit_prio_pick u_top_pick (
    .i_req          (I_REQ),
    .i_ctrl         (state_reg.ctrl),
    .i_level_filter (LVL_DISABLED),
    .o_found        (top_found),
    .o_src          (),
    .o_level        (top_level),
    .o_rank         ()
  );

  always_comb begin
    state_next           = state_reg;
    state_next.rdata     = 8'h00;
    state_next.irq_level = top_found ? top_level : LVL_DISABLED;
    // Reserved bits 7:6 are simply not stored
    if (I_WR && is_writable) begin
      state_next.ctrl[I_ADDR[5:0]] = I_WDATA[5:0];
    end
    if (I_RD) begin
      if (I_ADDR == ADDR_RECORD) begin
        state_next.rdata = state_reg.record;
      end else if (is_ctrl) begin
        state_next.rdata = {2'b00, state_reg.ctrl[I_ADDR[5:0]]};
      end else if (is_ack) begin
        if (ack_found) begin
          state_next.rdata   = 8'(VECTOR_BASE + {2'b00, ack_src});
          state_next.record  = {1'b0, ack_level, record_pri(ack_rank)};
          state_next.ack_src = ack_src;
        end else begin
          state_next.rdata   = 8'h00;
          state_next.record  = 8'h00;
          state_next.ack_src = 6'h00;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= reset_state();
    end else begin
      state_reg <= state_next;
    end
  end

  assign O_RDATA      = state_reg.rdata;
  assign O_IRQ_LEVEL  = state_reg.irq_level;
  assign O_ACK_SOURCE = state_reg.ack_src;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  logic [5:0] past_idx;
  assign past_idx = I_ADDR[5:0];

  ack_vector_a: assert property (
    I_RD && is_ack && ack_found |=>
      O_RDATA == 8'(VECTOR_BASE + {2'b00, $past(ack_src)}))
    else $error("Ack vector does not match winning source");

  record_load_a: assert property (
    I_RD && is_ack && ack_found |=>
      state_reg.record[6:4] == $past(ack_level) &&
      O_ACK_SOURCE == $past(ack_src))
    else $error("Ack record not loaded with level");

  record_layout_a: assert property (
    state_reg.record[7] == 1'b0 && state_reg.record[3:0] <= PRI_MID)
    else $error("Ack record holds reserved or bad priority");

  mid_point_a: assert property (
    I_RD && is_ack && ack_found && ack_src < 6'(FIRST_WRITABLE) |=>
      state_reg.record[3:0] == PRI_MID)
    else $error("Fixed source not recorded at mid-point");

  ctrl_write_a: assert property (
    I_WR && is_writable ##1 I_RD && I_ADDR == ADDR_RECORD + 8'(past_idx)
      && $past(past_idx) == past_idx |=>
      O_RDATA == {2'b00, $past(I_WDATA[5:0], 2)})
    else $error("Control write not read back");

  fixed_ro_a: assert property (
    I_WR && is_ctrl && !is_writable |=>
      state_reg.ctrl[$past(past_idx)] == $past(state_reg.ctrl[past_idx]))
    else $error("Fixed control register changed by write");

  disabled_src_a: assert property (
    ack_found |-> state_reg.ctrl[ack_src][5:3] != LVL_DISABLED &&
      ack_src != 6'(SRC_UNUSED))
    else $error("Disabled or unused source won");

  fixed_pri_read_a: assert property (
    I_RD && is_ctrl && !is_writable |=> O_RDATA[2:0] == PRI_FIXED_READ)
    else $error("Fixed source priority field not zero");

  empty_ack_a: assert property (
    I_RD && is_ack && !ack_found |=>
      O_RDATA == 8'h00 && state_reg.record == 8'h00)
    else $error("Empty ack did not return zero");

  reserved_zero_a: assert property (
    I_RD && is_ctrl |=> O_RDATA[7:6] == 2'b00)
    else $error("Control reserved bits not zero");

  write_lands_a: assert property (
    I_WR && is_writable |=>
      state_reg.ctrl[$past(past_idx)] == $past(I_WDATA[5:0]))
    else $error("Control write did not land");

  rdata_idle_a: assert property (
    !I_RD |=> O_RDATA == 8'h00)
    else $error("Read data not zero outside read answer");

  // Level output lags the request inputs by one register stage
  irq_level_a: assert property (
    1'b1 |=> O_IRQ_LEVEL == ($past(top_found) ? $past(top_level)
                                              : LVL_DISABLED))
    else $error("Request level output wrong");

  record_hold_a: assert property (
    !(I_RD && is_ack) |=> $stable(state_reg.record))
    else $error("Ack record changed without ack");

  sw_ack_top_a: assert property (
    I_RD && I_ADDR == ADDR_SW_ACK && ack_found |-> ack_level == top_level)
    else $error("Software ack missed the top level");

  used_src_a: assert property (
    ack_found |-> USED_MASK[ack_src] == 1'b1)
    else $error("Unwired source won arbitration");

  level_filter_a: assert property (
    I_RD && is_ack && ack_found && ack_filter != LVL_DISABLED |->
      ack_level == ack_filter ##1 O_IRQ_LEVEL >= $past(ack_level))
    else $error("Level ack picked wrong level");

  sw_ack_cov: cover property (I_RD && I_ADDR == ADDR_SW_ACK && ack_found);
  lvl_ack_cov: cover property (I_RD && is_ack && ack_filter != 3'h0
                               && ack_found);
  empty_cov: cover property (I_RD && is_ack && !ack_found);
  wr_cov: cover property (I_WR && is_writable ##1 I_RD && is_ack);
endmodule // interrupt_controller_unit_level_priority_ack

`default_nettype wire

// *** sim/core_ack_model.sv ***
// Core side model that issues acknowledge reads
`timescale 1ns/1ns
`default_nettype none

module core_ack_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic [7:0] i_ack_addr,
  input  wire logic [7:0] i_rdata,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_vector,
  output logic            o_done
);
  logic pend_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd     <= 1'b0;
      o_addr   <= 8'h00;
      o_vector <= 8'h00;
      o_done   <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      o_rd     <= i_go;
      pend_reg <= o_rd;
      o_done   <= pend_reg;
      if (i_go)
        o_addr <= i_ack_addr;
      // Vector is one byte, held until the next ack read captures it
      if (pend_reg)
        o_vector <= i_rdata;
    end
  end
endmodule // core_ack_model

`default_nettype wire

// *** sim/interrupt_controller_unit_level_priority_ack_tb_top.sv ***
// Self-checking bench for the acknowledge record block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module interrupt_controller_unit_level_priority_ack_tb_top;
  import interrupt_controller_unit_lp_pkg::*;
  typedef struct {
    int a; logic [7:0] ca; int b; logic [7:0] cb;
    logic [7:0] ack; logic [7:0] vec; logic [7:0] rec; logic [2:0] lvl;
  } row_t;
  logic clk = 0, rst = 1, b_wr = 0, b_rd = 0, go = 0;
  logic [63:1] req = '0;
  logic [7:0] b_addr = 8'h00, b_wdata = 8'h00, gaddr = 8'h00;
  logic [7:0] rdata, c_addr, vec, d;
  logic [2:0] lvl;
  logic [5:0] src;
  logic c_rd, done;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // Each row keeps level/priority pairs unique
  row_t rows[8] = '{
    '{8, 8'h2D, 9, 8'h2A, 8'h40, 8'h48, 8'h55, 3'h5},
    '{9, 8'h3F, 10, 8'h08, 8'h41, 8'h4A, 8'h10, 3'h7},
    '{12, 8'h1C, 3, 8'hFF, 8'h40, 8'h4C, 8'h34, 3'h3},
    '{13, 8'h1B, 3, 8'hFF, 8'h40, 8'h43, 8'h38, 3'h3},
    '{16, 8'h3F, 17, 8'h09, 8'h40, 8'h51, 8'h11, 3'h1},
    '{43, 8'h3F, 18, 8'h00, 8'h40, 8'h00, 8'h00, 3'h0},
    '{19, 8'h38, 36, 8'h37, 8'h46, 8'h64, 8'h67, 3'h7},
    '{20, 8'hED, 22, 8'h2C, 8'h40, 8'h54, 8'h55, 3'h5}};

  always #5 clk = ~clk;

  interrupt_controller_unit_level_priority_ack dut_u (
    .I_CLK(clk), .I_RST(rst), .I_REQ(req),
    .I_ADDR(c_rd ? c_addr : b_addr), .I_WDATA(b_wdata), .I_WR(b_wr),
    .I_RD(b_rd | c_rd), .O_RDATA(rdata), .O_IRQ_LEVEL(lvl),
    .O_ACK_SOURCE(src));

  core_ack_model core_u (
    .i_clk(clk), .i_rst(rst), .i_go(go), .i_ack_addr(gaddr),
    .i_rdata(rdata), .o_rd(c_rd), .o_addr(c_addr), .o_vector(vec),
    .o_done(done));

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    b_wr <= 1'b1; b_addr <= a; b_wdata <= v;
    @(posedge clk);
    b_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    b_rd <= 1'b1; b_addr <= a;
    @(posedge clk);
    b_rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic ack(input logic [7:0] a);
    @(posedge clk);
    go <= 1'b1; gaddr <= a;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    `CHK(done, 1'b1)
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Ceiling well above the roughly 200 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_RECORD, d); `CHK(d, 8'h00)
    for (int n = 1; n < 8; n++) begin
      wr(8'(n), 8'h3F);
      rd(8'(n), d); `CHK(d, 8'(n * 8))
    end
    rd(ADDR_WR_LO, d); `CHK(d, 8'h00)
    rd(8'h80, d); `CHK(d, 8'h00)
    foreach (rows[i]) begin
      wr(8'(rows[i].a), rows[i].ca);
      wr(8'(rows[i].b), rows[i].cb);
      req <= '0;
      req[rows[i].a] <= 1'b1;
      req[rows[i].b] <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CHK(lvl, rows[i].lvl)
      ack(rows[i].ack);
      `CHK(vec, rows[i].vec)
      `CHK(src, (rows[i].vec == 8'h00) ? 6'h00 : 6'(rows[i].vec - 8'h40))
      rd(ADDR_RECORD, d); `CHK(d, rows[i].rec)
      req <= '0;
      wr(8'(rows[i].a), 8'h00);
      wr(8'(rows[i].b), 8'h00);
    end
    wr(8'h21, 8'hED);
    rd(8'h21, d); `CHK(d, 8'h2D)
    wr(ADDR_RECORD, 8'h7F);
    rd(ADDR_RECORD, d); `CHK(d, 8'h55)
    req <= '0;
    req[5] <= 1'b1;
    ack(8'h47);
    `CHK(vec, 8'h00)
    rd(ADDR_RECORD, d); `CHK(d, 8'h00)
    // Back to back write then read, no idle cycle between strobes
    @(posedge clk);
    b_wr <= 1'b1; b_addr <= 8'h30; b_wdata <= 8'hD3;
    @(posedge clk);
    b_wr <= 1'b0; b_rd <= 1'b1;
    @(posedge clk);
    b_rd <= 1'b0;
    #1 `CHK(rdata, 8'h13)
    @(posedge clk);
    #1 `CHK(rdata, 8'h00)
    wr(ADDR_WR_LO, 8'h2D);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_WR_LO, d); `CHK(d, 8'h00)
    `CHK(src, 6'h00)
    summarize;
  end
endmodule // interrupt_controller_unit_level_priority_ack_tb_top

`default_nettype wire
